// *** rtl/fcpg_top.sv ***
// Four channel PWM generator: register file, shared 10-bit down counter,
// double-buffered period and duty values, interrupt logic.
// Assumes a simple byte register port; read data appear one cycle later.
// The brake function is not part of this block: a halted generator
// freezes its compare levels, so software parks them through the duty values
// before clearing run.
//
// Behaviour
// - Writing one to the counter clear bit sets the down counter to 000H.
// - The run bit starts the counter; clearing it halts it at its current value.
// - Each output is high while the counter is not below its duty, else low.
// - On underflow the counter reloads from the period value and repeats.
// - Period and duty are buffered and take effect at underflow with load set.
// - A duty above the reloaded period gives a permanently low output.
// - A duty of all zeroes gives a permanently high output.
// - A duty of all ones gives a permanently low output.
// - Each channel has an invert bit that flips its output.
// - After the transfer, load bit and underflow flag clear one cycle later.
// - Period and duty are 10 bits: low byte plus bits 1:0 of a high register.
// - After reset each internal output is one; rate is clock over (1 + prescale divisor) times (1 + period).
// - Load set without run never transfers, since transfer needs underflow.
// - The underflow flag reads one once the counter has underflowed.
`timescale 1ns/100ps
module fcpg_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [fcpg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [fcpg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [fcpg_pkg::DATA_W-1:0] o_rdata,
  // PWM outputs
  output logic [fcpg_pkg::NUM_CH-1:0] o_pwm,
  // Interrupt
  output logic o_irq
);
  import fcpg_pkg::*;

  // Channel index of a duty low-byte register, or 4 when not a duty low-byte register
  function automatic logic [2:0] duty_low_ch(input logic [7:0] a);
    case (a)
      OFS_DUTY_CH0_LOW_BYTE: duty_low_ch = 3'h0;
      OFS_DUTY_CH1_LOW_BYTE: duty_low_ch = 3'h1;
      OFS_DUTY_CH2_LOW_BYTE: duty_low_ch = 3'h2;
      OFS_DUTY_CH3_LOW_BYTE: duty_low_ch = 3'h3;
      default: duty_low_ch = 3'h4;
    endcase
  endfunction

  function automatic logic [2:0] duty_high_ch(input logic [7:0] a);
    case (a)
      OFS_DUTY_CH0_HIGH_BITS: duty_high_ch = 3'h0;
      OFS_DUTY_CH1_HIGH_BITS: duty_high_ch = 3'h1;
      OFS_DUTY_CH2_HIGH_BITS: duty_high_ch = 3'h2;
      OFS_DUTY_CH3_HIGH_BITS: duty_high_ch = 3'h3;
      default: duty_high_ch = 3'h4;
    endcase
  endfunction

  // Pads a 2-bit high field into a byte with zero reserved bits
  function automatic logic [7:0] high_byte(input logic [9:0] v);
    high_byte = {6'h00, v[9:8]};
  endfunction

  // A strobe beside a matching address selects one register
  function automatic logic hit(input logic s, input logic [7:0] a, input logic [7:0] ofs);
    hit = s && (a == ofs);
  endfunction

  // Buffered (software) values
  logic [9:0] period_buf_q;
  logic [9:0] duty_buf_q [NUM_CH];
  // Working values used by the counter and comparators
  logic [9:0] period_work_q;
  logic [9:0] duty_work_q [NUM_CH];
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;

  // Control bits
  logic run_q;
  logic load_q;
  logic flag_q;
  logic [NUM_CH-1:0] inv_q;
  logic [7:0] prescale_q;

  // Interrupt state
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;

  // Internal strobes
  logic tick;
  logic underflow;
  logic xfer;
  logic xfer_q;
  logic wr_ctl;
  logic clr_req;
  logic [2:0] wr_lo_ch;
  logic [2:0] wr_hi_ch;
  logic [7:0] rdata_d;
  logic wr_per_lo;
  logic wr_per_hi;
  logic wr_presc;
  logic wr_mask;
  logic rd_stat;
  logic [9:0] reload_val;

  // Register strobes, decoded once and shared by the update processes
  assign wr_ctl = hit(i_wr, i_addr, OFS_GENERATOR_CONTROL);
  assign wr_per_lo = hit(i_wr, i_addr, OFS_PERIOD_LOW_BYTE);
  assign wr_per_hi = hit(i_wr, i_addr, OFS_PERIOD_HIGH_BITS);
  assign wr_presc = hit(i_wr, i_addr, OFS_PRESCALE);
  assign wr_mask = hit(i_wr, i_addr, OFS_IRQ_MASK);
  assign rd_stat = hit(i_rd, i_addr, OFS_IRQ_STATUS);
  assign clr_req = wr_ctl && i_wdata[CTL_CLEAR_BIT];
  assign wr_lo_ch = i_wr ? duty_low_ch(i_addr) : 3'h4;
  assign wr_hi_ch = i_wr ? duty_high_ch(i_addr) : 3'h4;

  // Counter advances on prescaler ticks only while running
  fcpg_prescaler u_prescaler (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(run_q),
    .i_div(prescale_q),
    .o_tick(tick)
  );

  // Underflow is the step taken from zero; transfer needs load as well
  assign underflow = tick && (cnt_q == CNT_CLEAR_VAL);
  assign xfer = underflow && load_q;
  // New period is used at once when the transfer happens at this underflow
  assign reload_val = load_q ? period_buf_q : period_work_q;

  // Period buffer, split over two byte registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      period_buf_q <= {HI_W'(0), RST_BYTE};
    end else if (wr_per_lo) begin
      period_buf_q[7:0] <= i_wdata;
    end else if (wr_per_hi) begin
      period_buf_q[9:8] <= i_wdata[1:0];
    end
  end

  // Duty buffers, writable at any time without disturbing the output
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        duty_buf_q[c] <= {HI_W'(0), RST_BYTE};
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_lo_ch == 3'(c)) begin
          duty_buf_q[c][7:0] <= i_wdata;
        end
        if (wr_hi_ch == 3'(c)) begin
          duty_buf_q[c][9:8] <= i_wdata[1:0];
        end
      end
    end
  end

  // Working period changes only at an underflow with load pending
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      period_work_q <= CNT_CLEAR_VAL;
    end else if (xfer) begin
      period_work_q <= period_buf_q;
    end
  end

  // Working duties move with the period, so no period mixes old and new
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        duty_work_q[c] <= CNT_CLEAR_VAL;
      end
    end else if (xfer) begin
      for (int c = 0; c < NUM_CH; c++) begin
        duty_work_q[c] <= duty_buf_q[c];
      end
    end
  end

  // Next counter value; clear takes priority over counting
  always_comb begin
    cnt_d = cnt_q;
    if (clr_req) begin
      cnt_d = CNT_CLEAR_VAL;
    end else if (underflow) begin
      cnt_d = reload_val;
    end else if (tick) begin
      cnt_d = cnt_q - 10'h001;
    end
  end

  // Shared down counter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= CNT_CLEAR_VAL;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Transfer marker, one cycle after the underflow
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= xfer;
    end
  end

  // Run control; halting stops the prescaler and so the counter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
    end else if (wr_ctl) begin
      run_q <= i_wdata[CTL_RUN_BIT];
    end
  end

  // Invert controls, applied after the level so they act even when halted
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      inv_q <= '0;
    end else if (wr_ctl) begin
      inv_q <= i_wdata[CTL_INV_LSB +: NUM_CH];
    end
  end

  // Load bit: software sets it, hardware clears it after the transfer.
  // A software write in the clear cycle wins so a new request is kept.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      load_q <= 1'b0;
    end else if (wr_ctl) begin
      load_q <= i_wdata[CTL_LOAD_BIT];
    end else if (xfer_q) begin
      load_q <= 1'b0;
    end
  end

  // Underflow flag: a fresh underflow beats any clear in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (underflow) begin
      flag_q <= 1'b1;
    end else if (wr_ctl) begin
      flag_q <= i_wdata[CTL_FLAG_BIT];
    end else if (xfer_q) begin
      flag_q <= 1'b0;
    end
  end

  // Prescale divisor, added for slower counter rates
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale_q <= PRESCALE_RST;
    end else if (wr_presc) begin
      prescale_q <= i_wdata;
    end
  end

  // Interrupt mask
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= i_wdata[IRQ_W-1:0];
    end
  end

  // Sticky status, cleared by a read; a new event in that cycle survives
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= '0;
    end else begin
      if (rd_stat) begin
        irq_stat_q <= '0;
      end
      if (underflow) begin
        irq_stat_q[IRQ_UNDERFLOW_BIT] <= 1'b1;
      end
      if (xfer) begin
        irq_stat_q[IRQ_TRANSFER_BIT] <= 1'b1;
      end
    end
  end

  // Level interrupt from any unmasked status bit
  // Left combinational so a mask write reaches the pin in the next cycle
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Read decode; reserved bits and unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (i_addr)
      OFS_PERIOD_LOW_BYTE: rdata_d = period_buf_q[7:0];
      OFS_PERIOD_HIGH_BITS: rdata_d = high_byte(period_buf_q);
      OFS_DUTY_CH0_LOW_BYTE: rdata_d = duty_buf_q[0][7:0];
      OFS_DUTY_CH1_LOW_BYTE: rdata_d = duty_buf_q[1][7:0];
      OFS_DUTY_CH2_LOW_BYTE: rdata_d = duty_buf_q[2][7:0];
      OFS_DUTY_CH3_LOW_BYTE: rdata_d = duty_buf_q[3][7:0];
      OFS_DUTY_CH0_HIGH_BITS: rdata_d = high_byte(duty_buf_q[0]);
      OFS_DUTY_CH1_HIGH_BITS: rdata_d = high_byte(duty_buf_q[1]);
      OFS_DUTY_CH2_HIGH_BITS: rdata_d = high_byte(duty_buf_q[2]);
      OFS_DUTY_CH3_HIGH_BITS: rdata_d = high_byte(duty_buf_q[3]);
      OFS_GENERATOR_CONTROL: begin
        // Clear bit is a strobe and always reads zero
        rdata_d = {run_q, load_q, flag_q, 1'b0, inv_q};
      end
      OFS_IRQ_STATUS: rdata_d = {6'h00, irq_stat_q};
      OFS_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
      OFS_PRESCALE: rdata_d = prescale_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data held only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // One comparator per channel against the shared counter
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    fcpg_channel u_channel (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_step(tick),
      .i_cnt(cnt_q),
      .i_duty(duty_work_q[g]),
      .i_inv(inv_q[g]),
      .o_pwm(o_pwm[g])
    );
  end
endmodule // fcpg_top

// *** rtl/fcpg_pkg.sv ***
// Package for the four channel PWM generator: register map, field positions
// and reset values. Assumes an 8-bit register port with byte-wide data.
package fcpg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned HI_W = 2;

  // Register offsets
  localparam logic [7:0] OFS_PERIOD_HIGH_BITS = 8'hD1;
  localparam logic [7:0] OFS_DUTY_CH0_HIGH_BITS = 8'hD2;
  localparam logic [7:0] OFS_DUTY_CH1_HIGH_BITS = 8'hD3;
  localparam logic [7:0] OFS_DUTY_CH2_HIGH_BITS = 8'hD5;
  localparam logic [7:0] OFS_DUTY_CH3_HIGH_BITS = 8'hD6;
  localparam logic [7:0] OFS_PERIOD_LOW_BYTE = 8'hD9;
  localparam logic [7:0] OFS_DUTY_CH0_LOW_BYTE = 8'hDA;
  localparam logic [7:0] OFS_DUTY_CH1_LOW_BYTE = 8'hDB;
  localparam logic [7:0] OFS_GENERATOR_CONTROL = 8'hDC;
  localparam logic [7:0] OFS_DUTY_CH2_LOW_BYTE = 8'hDD;
  localparam logic [7:0] OFS_DUTY_CH3_LOW_BYTE = 8'hDE;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hE1;
  localparam logic [7:0] OFS_PRESCALE = 8'hE2;

  // Control register fields
  localparam int unsigned CTL_RUN_BIT = 7;
  localparam int unsigned CTL_LOAD_BIT = 6;
  localparam int unsigned CTL_FLAG_BIT = 5;
  localparam int unsigned CTL_CLEAR_BIT = 4;
  localparam int unsigned CTL_INV_LSB = 0;

  // Interrupt status fields
  localparam int unsigned IRQ_UNDERFLOW_BIT = 0;
  localparam int unsigned IRQ_TRANSFER_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  // Reset and special values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] CNT_CLEAR_VAL = 10'h000;
  localparam logic [9:0] DUTY_ALL_ONES = 10'h3FF;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic PWM_LEVEL_RST = 1'b1;
endpackage : fcpg_pkg

// *** rtl/fcpg_prescaler.sv ***
// Clock prescaler: one-cycle enable every (divisor + 1) clocks.
// Assumes the divisor is held stable by software while running.
`timescale 1ns/100ps
module fcpg_prescaler (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic [7:0] i_div,
  // Enable out
  output logic o_tick
);
  import fcpg_pkg::*;

  logic [7:0] cnt_q;

  // Restart when halted so the first tick after run is a full interval
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
    end else if (!i_run || o_tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign o_tick = i_run && (cnt_q == i_div);
endmodule // fcpg_prescaler

// *** rtl/fcpg_channel.sv ***
// One PWM channel: compare of the shared counter against the working duty.
// Assumes counter and duty are the working (transferred) values.
`timescale 1ns/100ps
module fcpg_channel (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Timing
  input wire logic i_step,
  input wire logic [9:0] i_cnt,
  // Settings
  input wire logic [9:0] i_duty,
  input wire logic i_inv,
  // Output
  output logic o_pwm
);
  import fcpg_pkg::*;

  logic level_q;
  logic level_d;

  // High while counter not below duty; all ones forces low
  always_comb begin
    level_d = (i_cnt >= i_duty);
    if (i_duty == DUTY_ALL_ONES) begin
      level_d = 1'b0;
    end
  end

  // Level only moves on counter steps, so it freezes when halted
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      level_q <= PWM_LEVEL_RST;
    end else if (i_step) begin
      level_q <= level_d;
    end
  end

  // Invert stage registered so the pin comes from a flop
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pwm <= PWM_LEVEL_RST;
    end else begin
      o_pwm <= level_q ^ i_inv;
    end
  end
endmodule // fcpg_channel

// *** dv/fcpg_sva.sv ***
// Port checker for the four channel PWM generator register port and interrupt.
// Assumes one clock domain and the byte register map of fcpg_pkg.
`timescale 1ns/100ps
module fcpg_sva (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [fcpg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [fcpg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [fcpg_pkg::DATA_W-1:0] o_rdata,
  // Outputs
  input wire logic [fcpg_pkg::NUM_CH-1:0] o_pwm,
  input wire logic o_irq
);
  import fcpg_pkg::*;

  default clocking dflt_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // Read data stand one cycle only, else zero
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside answer");
  unmapped_rd_a: assert property (i_rd && !(i_addr inside {[8'hD1:8'hE2]})
    |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  hi_reserved_a: assert property (i_rd &&
    (i_addr inside {8'hD1, 8'hD2, 8'hD3, 8'hD5, 8'hD6}) |=> o_rdata[7:2] == 6'h00)
    else $error("reserved high bits not zero");
  // Clear is a strobe, so it never reads back
  clear_reads_a: assert property (i_rd && i_addr == OFS_GENERATOR_CONTROL
    |=> !o_rdata[CTL_CLEAR_BIT])
    else $error("clear bit reads one");
  low_rw_a: assert property (i_wr && i_addr == OFS_DUTY_CH0_LOW_BYTE ##1
    i_rd && i_addr == OFS_DUTY_CH0_LOW_BYTE |=> o_rdata == $past(i_wdata, 2))
    else $error("low byte read back wrong");
  high_rw_a: assert property (i_wr && i_addr == OFS_DUTY_CH0_HIGH_BITS ##1
    i_rd && i_addr == OFS_DUTY_CH0_HIGH_BITS
    |=> o_rdata == ($past(i_wdata, 2) & 8'h03))
    else $error("high bits read back wrong");
  // Load excluded: hardware may clear it meanwhile
  ctrl_rw_a: assert property (i_wr && i_addr == OFS_GENERATOR_CONTROL &&
    !i_wdata[CTL_LOAD_BIT] ##1 i_rd && i_addr == OFS_GENERATOR_CONTROL
    |=> (o_rdata & 8'h8F) == ($past(i_wdata, 2) & 8'h8F))
    else $error("control read back wrong");
  mask_off_a: assert property (i_wr && i_addr == OFS_IRQ_MASK && i_wdata == 8'h00
    |=> !o_irq)
    else $error("interrupt with mask cleared");
  // Levels start at one and inverts at zero, so every pin leaves reset high
  pwm_reset_a: assert property ($fell(i_rst) |-> o_pwm == 4'hF)
    else $error("outputs not high after reset");
endmodule // fcpg_sva

bind fcpg_top fcpg_sva i_fcpg_sva (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_pwm(o_pwm),
  .o_irq(o_irq)
);

// *** dv/fcpg_load_model.sv ***
// Load model on the PWM pins: counts high cycles per channel in a window.
// Assumes the bench pulses i_clr to open each window.
`timescale 1ns/100ps
module fcpg_load_model (
  // Clock and window start
  input wire logic i_ref_clk,
  input wire logic i_clr,
  // Pins
  input wire logic [3:0] i_pin,
  // High counts, 16 bits per channel
  output logic [63:0] o_hi_cnt
);
  // Loads are passive, so the model only watches
  always_ff @(posedge i_ref_clk) begin
    for (int n = 0; n < 4; n++) begin
      if (i_clr) begin
        o_hi_cnt[n*16 +: 16] <= 16'h0000;
      end else begin
        o_hi_cnt[n*16 +: 16] <= o_hi_cnt[n*16 +: 16] + {15'h0000, i_pin[n]};
      end
    end
  end
endmodule // fcpg_load_model

// *** dv/tb_top.sv ***
// Self-checking bench: register tasks, PWM window counts, interrupt checks.
// Assumes the prescaler stays at reset value, so the counter steps every clock.
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_top;
  import fcpg_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [3:0] o_pwm;
  logic o_irq;
  logic clr = 1'b0;
  logic [63:0] hi_cnt;
  logic [7:0] rd_v;
  logic [3:0] pw;
  logic [3:0] pw0;
  logic iq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Every mapped place plus one unmapped place
  localparam logic [7:0] RST_A [15] = '{8'hD1, 8'hD2, 8'hD3, 8'hD5, 8'hD6, 8'hD9, 8'hDA,
    8'hDB, 8'hDD, 8'hDE, 8'hDC, 8'hE0, 8'hE1, 8'hE2, 8'h10};
  // Period 7; duties 2, 0, 3FF and 104 (above period)
  localparam logic [7:0] CFG_A [10] = '{8'hD9, 8'hD1, 8'hD2, 8'hDB, 8'hD3, 8'hDD, 8'hD5,
    8'hDE, 8'hD6, 8'hE1};
  localparam logic [7:0] CFG_D [10] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03,
    8'h04, 8'h01, 8'h00};

  fcpg_top i_fcpg_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm(o_pwm),
    .o_irq(o_irq));
  fcpg_load_model i_fcpg_load_model (.i_ref_clk(i_ref_clk), .i_clr(clr), .i_pin(o_pwm),
    .o_hi_cnt(hi_cnt));

  // Strobe stays high so back-to-back writes never assign twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_rd <= 1'b0;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
  endtask
  // Answer taken at the falling edge, away from the design's updates
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    rd_v = o_rdata;
    @(posedge i_ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rd(a);
    `CHK($sformatf("reg %h", a), e, rd_v & m)
  endtask
  task automatic look(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    pw = o_pwm;
    iq = o_irq;
    @(posedge i_ref_clk);
  endtask
  // Four whole periods of eight ticks: 32 samples, read away from the edge
  task automatic window(input logic [63:0] ex);
    clr <= 1'b1;
    look(0);
    clr <= 1'b0;
    repeat (32) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK("high counts", ex, hi_cnt)
    @(posedge i_ref_clk);
  endtask
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Hang guard, far above the roughly 150 cycles needed
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin : main
    int k;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    foreach (RST_A[j]) begin
      rdc(RST_A[j], 8'h00, 8'hFF);
    end
    look(0);
    `CHK("pwm after reset", 4'hF, pw)
    $display("test reset done");
    wr(8'hDA, 8'h02);
    rdc(8'hDA, 8'h02, 8'hFF);
    wr(8'hD2, 8'hFD);
    rdc(8'hD2, 8'h01, 8'hFF);
    wr(8'h10, 8'h5A);
    rdc(8'h10, 8'h00, 8'hFF);
    $display("test registers done");
    // Clear, set values, then run with load and inverts on 1 and 3
    wr(8'hDC, 8'h10);
    foreach (CFG_A[j]) begin
      wr(CFG_A[j], CFG_D[j]);
    end
    wr(8'hDC, 8'hCA);
    rd(8'hDC);
    for (k = 0; k < 40 && rd_v[6] !== 1'b0; k++) begin
      rd(8'hDC);
    end
    `CHK("load bit", 1'b0, rd_v[6])
    window(64'h0020_0000_0000_0018);
    rdc(8'hDC, 8'hAA, 8'hFF);
    $display("test run done");
    look(0);
    `CHK("irq masked", 1'b0, iq)
    wr(8'hE1, 8'h03);
    look(0);
    `CHK("irq raised", 1'b1, iq)
    $display("test irq done");
    // Halt, then outputs hold while load without run waits
    wr(8'hDC, 8'h0A);
    rdc(8'hDC, 8'h0A, 8'h8F);
    look(0);
    pw0 = pw;
    rdc(8'hE0, 8'h03, 8'hFF);
    look(2);
    `CHK("irq cleared", 1'b0, iq)
    wr(8'hDA, 8'h05);
    wr(8'hDC, 8'h5A);
    look(20);
    `CHK("pwm frozen", pw0, pw)
    rdc(8'hDC, 8'h4A, 8'hFF);
    $display("test halt done");
    complete_run();
  end
endmodule // tb_top
